// [logic/motion_request_defines.vh]
/*
  constants for the motion unit request handshake block:
  bit positions of the request and flag words, timing figures, limits.
  assumes a 100 MHz clock; included by bare name.
*/
`ifndef MOTION_REQUEST_DEFINES_VH
`define MOTION_REQUEST_DEFINES_VH

// ****************************************
// request word bit positions
// ****************************************
`define REQ_WORD_W 16
`define REQ_SYSTEM_STOP 0
`define REQ_PACKET_CAPTURE 1
`define REQ_FLASH_STORE 3
`define REQ_GROUP_CHANGE 5
`define REQ_TABLE_REBUILD 7

// ****************************************
// flag word bit positions
// ****************************************
`define FLAG_PACKET_CAPTURE_ACTIVE 1
`define FLAG_FLASH_STORE_BUSY 3
`define FLAG_GROUP_CHANGE_DONE 5
`define FLAG_TABLE_REBUILD_DONE 7

// ****************************************
// timing and limits
// ****************************************
`define CLK_PERIOD_NS 10
`define STOP_DECEL_TIME_NS 1000000
`define STOP_DECEL_CYCLES (`STOP_DECEL_TIME_NS / `CLK_PERIOD_NS)
`define CAPTURE_MAX_BYTES 6291456
`define CAPTURE_MAX_PACKETS 3904
`define STORE_RESULT_OK 16'h0000
`define STORE_RESULT_FAIL 16'h0001
`define STORE_RESULT_ADDR 9'h11b
`define ZERO_WORD 16'h0000

`endif

// [logic/motion_job_sequencer.v]
/*
  motion_job_sequencer: one request/done sequencer for a long internal job.
  starts a job on a request rise, waits for job_done, then shows done until
  the next request rise. assumes job_done is a one-cycle pulse from the engine.
*/
`timescale 1ns/1ns

module motion_job_sequencer
(
  input wire clk,
  input wire rst,
  input wire request,
  input wire job_done,
  output reg job_start_q,
  output reg busy_q,
  output reg done_q
);

  localparam IDLE = 3'b001;
  localparam RUN = 3'b010;
  localparam HOLD = 3'b100;

  reg [2:0] state_q;
  reg req_prev_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= IDLE;
      req_prev_q <= 1'b0;
      job_start_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      req_prev_q <= request;
      job_start_q <= 1'b0;
      case (state_q)
        IDLE:
        begin
          if (request && !req_prev_q)
          begin
            // new request drops any old done first
            state_q <= RUN;
            job_start_q <= 1'b1;
            busy_q <= 1'b1;
            done_q <= 1'b0;
          end
        end
        RUN:
        begin
          if (job_done)
          begin
            state_q <= HOLD;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        HOLD:
        begin
          if (!request)
          begin
            state_q <= IDLE;
          end
        end
        default:
        begin
          state_q <= IDLE;
          busy_q <= 1'b0;
          done_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // motion_job_sequencer

// [logic/motion_unit_request_handshake.v]
/*
  motion_unit_request_handshake: takes the host request word and answers
  through the flag word; drives axis halt and packet capture outputs, and start/done
  handshakes with internal engines (flash store, group apply, table rebuild).
  assumes the request word is already mapped from base word by the host side.
*/
`timescale 1ns/1ns
`include "motion_request_defines.vh"

module motion_unit_request_handshake
#(
  parameter NUM_AXES = 16,
  parameter STOP_DECEL_CYCLES = `STOP_DECEL_CYCLES,
  parameter CAPTURE_MAX_BYTES = `CAPTURE_MAX_BYTES,
  parameter CAPTURE_MAX_PACKETS = `CAPTURE_MAX_PACKETS
)
(
  input wire clk,
  input wire rst,
  input wire [`REQ_WORD_W-1:0] request_output_word,
  input wire capture_enable,
  input wire [NUM_AXES-1:0] axis_start_req,
  input wire packet_valid,
  input wire [15:0] packet_bytes,
  input wire flash_copy_done,
  input wire flash_copy_ok,
  input wire group_apply_done,
  input wire table_rebuild_finished,
  input wire [15:0] rebuild_start_table,
  output reg [`REQ_WORD_W-1:0] flag_word_q,
  output reg [NUM_AXES-1:0] axis_start_grant_q,
  output reg [NUM_AXES-1:0] axis_halt_q,
  output reg [31:0] axis_decel_cycles_q,
  output reg card_write_valid_q,
  output reg [15:0] card_write_bytes_q,
  output reg flash_copy_start_q,
  output reg [15:0] store_result_word_q,
  output reg [8:0] store_result_addr_q,
  output reg store_result_write_q,
  output reg group_apply_start_q,
  output reg table_rebuild_start_q,
  output reg [15:0] rebuild_start_table_q,
  output reg table_exec_enable_q
);

  // ****************************************
  // request decode
  // ****************************************
  // only defined positions are picked; others never read
  wire stop_req = request_output_word[`REQ_SYSTEM_STOP];
  wire capture_req = request_output_word[`REQ_PACKET_CAPTURE];
  wire store_req = request_output_word[`REQ_FLASH_STORE];
  wire group_req = request_output_word[`REQ_GROUP_CHANGE];
  wire rebuild_req = request_output_word[`REQ_TABLE_REBUILD];

  reg capture_req_prev_q;
  reg capture_active_q;
  reg [31:0] capture_byte_cnt_q;
  reg [15:0] capture_pkt_cnt_q;
  reg store_waiting_q;

  wire flash_start;
  wire flash_busy;
  wire group_start;
  wire group_done;
  wire rebuild_start;
  wire rebuild_done;

  // ****************************************
  // job sequencers
  // ****************************************
  motion_job_sequencer store_seq
  (
    .clk(clk),
    .rst(rst),
    .request(store_req),
    .job_done(flash_copy_done),
    .job_start_q(flash_start),
    .busy_q(flash_busy),
    .done_q()
  );

  motion_job_sequencer group_seq
  (
    .clk(clk),
    .rst(rst),
    .request(group_req),
    .job_done(group_apply_done),
    .job_start_q(group_start),
    .busy_q(),
    .done_q(group_done)
  );

  motion_job_sequencer rebuild_seq
  (
    .clk(clk),
    .rst(rst),
    .request(rebuild_req),
    .job_done(table_rebuild_finished),
    .job_start_q(rebuild_start),
    .busy_q(),
    .done_q(rebuild_done)
  );

  // ****************************************
  // axis stop and start gating
  // ****************************************
  genvar ax;
  generate
    for (ax = 0; ax < NUM_AXES; ax = ax + 1)
    begin : axis_gate
      always @(posedge clk)
      begin
        if (rst)
        begin
          axis_halt_q[ax] <= 1'b0;
          axis_start_grant_q[ax] <= 1'b0;
        end
        else
        begin
          axis_halt_q[ax] <= stop_req;
          axis_start_grant_q[ax] <= axis_start_req[ax] & ~stop_req;
        end
      end
    end
  endgenerate

  // ****************************************
  // packet capture
  // ****************************************
  wire [31:0] bytes_next = capture_byte_cnt_q + {16'h0000, packet_bytes};
  wire capture_limit = (bytes_next >= CAPTURE_MAX_BYTES)
                       || ({16'h0000, capture_pkt_cnt_q} + 32'h0000_0001 >= CAPTURE_MAX_PACKETS);

  always @(posedge clk)
  begin
    if (rst)
    begin
      capture_req_prev_q <= 1'b0;
      capture_active_q <= 1'b0;
      capture_byte_cnt_q <= 32'h0000_0000;
      capture_pkt_cnt_q <= 16'h0000;
      card_write_valid_q <= 1'b0;
      card_write_bytes_q <= 16'h0000;
    end
    else
    begin
      capture_req_prev_q <= capture_req;
      card_write_valid_q <= 1'b0;
      if (!capture_active_q)
      begin
        if (capture_req && !capture_req_prev_q && capture_enable)
        begin
          capture_active_q <= 1'b1;
          capture_byte_cnt_q <= 32'h0000_0000;
          capture_pkt_cnt_q <= 16'h0000;
        end
      end
      else if (!capture_req)
      begin
        capture_active_q <= 1'b0;
      end
      else if (packet_valid)
      begin
        card_write_valid_q <= 1'b1;
        card_write_bytes_q <= packet_bytes;
        capture_byte_cnt_q <= bytes_next;
        capture_pkt_cnt_q <= capture_pkt_cnt_q + 16'h0001;
        if (capture_limit)
        begin
          capture_active_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // flash store result and engine starts
  // ****************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      store_waiting_q <= 1'b0;
      flash_copy_start_q <= 1'b0;
      store_result_word_q <= `ZERO_WORD;
      store_result_addr_q <= 9'h000;
      store_result_write_q <= 1'b0;
      group_apply_start_q <= 1'b0;
      table_rebuild_start_q <= 1'b0;
      rebuild_start_table_q <= 16'h0000;
      table_exec_enable_q <= 1'b0;
    end
    else
    begin
      flash_copy_start_q <= flash_start;
      group_apply_start_q <= group_start;
      table_rebuild_start_q <= rebuild_start;
      store_result_write_q <= 1'b0;
      store_result_addr_q <= `STORE_RESULT_ADDR;
      if (flash_start)
      begin
        store_waiting_q <= 1'b1;
      end
      else if (store_waiting_q && flash_copy_done)
      begin
        store_waiting_q <= 1'b0;
        store_result_write_q <= 1'b1;
        store_result_word_q <= flash_copy_ok ? `STORE_RESULT_OK : `STORE_RESULT_FAIL;
      end
      if (rebuild_start)
      begin
        rebuild_start_table_q <= rebuild_start_table;
        table_exec_enable_q <= 1'b0;
      end
      else if (rebuild_done)
      begin
        table_exec_enable_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // flag word and decel setting
  // ****************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      flag_word_q <= `ZERO_WORD;
      axis_decel_cycles_q <= 32'h0000_0000;
    end
    else
    begin
      axis_decel_cycles_q <= STOP_DECEL_CYCLES;
      flag_word_q <= `ZERO_WORD;
      flag_word_q[`FLAG_PACKET_CAPTURE_ACTIVE] <= capture_active_q;
      flag_word_q[`FLAG_FLASH_STORE_BUSY] <= flash_busy;
      flag_word_q[`FLAG_GROUP_CHANGE_DONE] <= group_done;
      flag_word_q[`FLAG_TABLE_REBUILD_DONE] <= rebuild_done;
    end
  end

endmodule // motion_unit_request_handshake

// [sim/req_checker_properties.sv]
/* checker for the request handshake block.
   assumes bind onto the top module, one clk domain. */
`timescale 1ns/1ns
module req_checker
#(
  parameter NUM_AXES = 16,
  parameter STOP_DECEL_CYCLES = 10
)
(
  input wire clk,
  input wire rst,
  input wire [15:0] request_output_word,
  input wire [NUM_AXES-1:0] axis_start_req,
  input wire [15:0] flag_word_q,
  input wire [NUM_AXES-1:0] axis_start_grant_q,
  input wire [NUM_AXES-1:0] axis_halt_q,
  input wire [31:0] axis_decel_cycles_q,
  input wire flash_copy_start_q,
  input wire store_result_write_q,
  input wire [8:0] store_result_addr_q,
  input wire table_rebuild_start_q
);
  // ****
  // properties
  // ****
  reg [1:0] up_q;
  always @(posedge clk) up_q <= rst ? 2'b00 : {up_q[0], 1'b1};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  halt_all_a: assert property (up_q[1] |-> axis_halt_q == {NUM_AXES{$past(request_output_word[0])}})
    else $error("halt mismatch");
  decel_time_a: assert property (up_q[1] |-> axis_decel_cycles_q == STOP_DECEL_CYCLES)
    else $error("decel mismatch");
  start_refused_a: assert property (up_q[1] |->
    axis_start_grant_q == ($past(axis_start_req) & {NUM_AXES{!$past(request_output_word[0])}}))
    else $error("grant mismatch");
  busy_rise_a: assert property (flash_copy_start_q |=> flag_word_q[3])
    else $error("busy not raised");
  busy_drop_a: assert property (store_result_write_q |=> !flag_word_q[3])
    else $error("busy not dropped");
  result_addr_a: assert property (store_result_write_q |-> store_result_addr_q == 9'h11b)
    else $error("result address");
  capture_stop_a: assert property ((!request_output_word[1]) [*4] |-> !flag_word_q[1])
    else $error("capture still active");
  done_drop_a: assert property (table_rebuild_start_q |-> ##[0:3] !flag_word_q[7])
    else $error("rebuild done kept");
  reserved_zero_a: assert property ((flag_word_q & 16'hff55) == 16'h0000)
    else $error("reserved flag set");
endmodule // req_checker
bind motion_unit_request_handshake req_checker #(.NUM_AXES(NUM_AXES), .STOP_DECEL_CYCLES(STOP_DECEL_CYCLES)) chk (.*);

// [sim/far_engines.sv]
/* model of the internal engines behind the block.
   assumes one-cycle start pulses; answers after lat cycles. */
`timescale 1ns/1ns
module far_engines
(
  input wire clk,
  input wire rst,
  input wire [7:0] lat,
  input wire fail,
  input wire [2:0] start,
  output reg [2:0] done_q,
  output reg ok_q
);
  // ****
  // engines
  // ****
  reg [7:0] cnt_q [0:2];
  integer i;
  always @(posedge clk)
  begin
    ok_q <= (cnt_q[0] == 8'h01) ? !fail : fail;
    for (i = 0; i < 3; i = i + 1)
    begin
      done_q[i] <= !rst && cnt_q[i] == 8'h01;
      if (rst) cnt_q[i] <= 8'h00;
      else if (start[i]) cnt_q[i] <= lat;
      else if (cnt_q[i] != 8'h00) cnt_q[i] <= cnt_q[i] - 8'h01;
    end
  end
endmodule // far_engines

// [sim/testbench.sv]
/* self-checking bench for the request handshake block.
   assumes far_engines answers the start pulses. */
`timescale 1ns/1ns
`include "motion_request_defines.vh"
module testbench;
  // ****
  // harness
  // ****
  reg clk = 0, rst = 1, ena = 0, pv = 0, fail = 0;
  reg [15:0] rq = 16'h0000, ax = 16'h0000, tbl = 16'h0000, pb = 16'h0040;
  reg [7:0] lat = 8'h01;
  wire [15:0] fw, gr, hl, srw, rtq, wb;
  wire [31:0] dc;
  wire [2:0] st, dn;
  wire cv, ok, ex;
  integer err_count = 0, tests_run = 0, cyc = 0, cards = 0, k;
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    cards <= rst ? 0 : cards + cv;
    if (cyc == 30000)
    begin
      err_count = err_count + 1;
      results;
    end
  end
  far_engines eng (.clk(clk), .rst(rst), .lat(lat), .fail(fail), .start(st), .done_q(dn), .ok_q(ok));
  motion_unit_request_handshake #(.STOP_DECEL_CYCLES(10), .CAPTURE_MAX_BYTES(400), .CAPTURE_MAX_PACKETS(4))
    DUT (.clk(clk), .rst(rst),
    .request_output_word(rq), .capture_enable(ena), .axis_start_req(ax), .packet_valid(pv),
    .packet_bytes(pb), .flash_copy_done(dn[0]), .flash_copy_ok(ok), .group_apply_done(dn[1]),
    .table_rebuild_finished(dn[2]), .rebuild_start_table(tbl), .flag_word_q(fw), .axis_start_grant_q(gr),
    .axis_halt_q(hl), .axis_decel_cycles_q(dc), .card_write_valid_q(cv), .card_write_bytes_q(wb),
    .flash_copy_start_q(st[0]), .store_result_word_q(srw), .store_result_addr_q(), .store_result_write_q(),
    .group_apply_start_q(st[1]), .table_rebuild_start_q(st[2]), .rebuild_start_table_q(rtq),
    .table_exec_enable_q(ex));
  // ****
  // tasks
  // ****
  task step(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task set(input integer b, input v);
    @(posedge clk) rq[b] <= v;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wflag(input integer b, input v);
    integer n;
    n = 0;
    while (fw[b] !== v && n < 300)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk(fw[b], v);
  endtask
  task results;
    $display("counts: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    step(16);
    rst <= 0;
    step(2);
    ax <= 16'hffff;
    set(0, 1);
    step(3);
    chk(gr, 16'h0000);
    chk(hl, 16'hffff);
    chk(dc, 10);
    set(0, 0);
    step(3);
    chk(gr, 16'hffff);
    chk(hl, 16'h0000);
    $display("test stop done");
    for (k = 0; k < 2; k = k + 1)
    begin
      fail <= k;
      lat <= k ? 8'h1e : 8'h01;
      set(3, 1);
      wflag(3, 1);
      wflag(3, 0);
      chk(srw, k ? `STORE_RESULT_FAIL : `STORE_RESULT_OK);
      set(3, 0);
      step(2);
    end
    $display("test store done");
    @(posedge clk) rq <= 16'hff74;
    wflag(5, 1);
    @(posedge clk) rq <= 16'h0000;
    $display("test group done");
    tbl <= 16'h0005;
    set(7, 1);
    wflag(7, 1);
    chk(rtq, 16'h0005);
    chk(ex, 1);
    set(7, 0);
    step(2);
    set(7, 1);
    wflag(7, 0);
    wflag(7, 1);
    set(7, 0);
    $display("test rebuild done");
    set(1, 1);
    step(8);
    chk(fw[1], 0);
    set(1, 0);
    ena <= 1;
    set(1, 1);
    wflag(1, 1);
    repeat (4)
    begin
      @(posedge clk) pv <= 1;
      @(posedge clk) pv <= 0;
    end
    wflag(1, 0);
    chk(cards, 4);
    chk(wb, 16'h0040);
    set(1, 0);
    step(2);
    set(1, 1);
    wflag(1, 1);
    set(1, 0);
    wflag(1, 0);
    pb <= 16'h00c8;
    set(1, 1);
    wflag(1, 1);
    repeat (2)
    begin
      @(posedge clk) pv <= 1;
      @(posedge clk) pv <= 0;
    end
    wflag(1, 0);
    chk(cards, 6);
    chk(wb, 16'h00c8);
    set(1, 0);
    step(2);
    $display("test capture done");
    results;
  end
endmodule // testbench
